//--- core/prs_defines.svh
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and internal timing
// ----------------------------------------------------------------
`define PRS_CLK_HZ             125000000
`define PRS_UPDATE_HZ          444
`define PRS_SAMPLE_CYCLES      (`PRS_CLK_HZ / `PRS_UPDATE_HZ)
`define PRS_DETECT_MS          40
`define PRS_DETECT_CYCLES      (`PRS_DETECT_MS * (`PRS_CLK_HZ / 1000))
`define PRS_SETTLE_MS          80
`define PRS_SETTLE_CYCLES      (`PRS_SETTLE_MS * (`PRS_CLK_HZ / 1000))
`define PRS_STRETCH_US         15
`define PRS_STRETCH_CYCLES     11'((`PRS_STRETCH_US * (`PRS_CLK_HZ / 1000000)))

// ----------------------------------------------------------------
// Host-side SPI timing, microseconds
// ----------------------------------------------------------------
`define PRS_SELECT_TO_CLOCK_GAP_US   100
`define PRS_CLOCK_PERIOD_US          6
`define PRS_INTER_BYTE_GAP_US        100
`define PRS_CLOCK_TO_DESELECT_GAP_US 20
`define PRS_DESELECT_HIGH_US         6

// ----------------------------------------------------------------
// Frame and register layout
// ----------------------------------------------------------------
`define PRS_SPI_BITS           5'h10
`define PRS_MODE_RESET         8'hF6
`define PRS_RATE_RESET         8'h00
`define PRS_RANGE_LSB          0
`define PRS_WDOG_BIT           3
`define PRS_BW_LSB             4
`define PRS_NOTCH_BIT          7
`define PRS_I2C_BASE_ADDR      7'h28
`define PRS_I2C_ADDR_MAX       4'h9

`endif

//--- core/prs_host_port.sv
// What this block does
// - Sample select once after detect delay.
// - Flag results unsettled during settling interval.
// - SPI frames 16 bits, MSB first.
// - SPI: mode, rate in; pressure out.
// - Hold mode and rate configuration registers.
// - Rate throttles data ready from 444 Hz.
// - A full 16-bit SPI frame or a two-wire read clears data ready.
// - I2C address 0x28 plus strap level, level capped at 9.
// - Two-wire port is slave only.
// - Two-wire write configures, read returns pressure.
// - Rate reloads divider; zero means auto.
// - New mode active from the next transfer.
// - Mode fields: range, watchdog, bandwidth, notch.
// - Stretch clock low after acknowledge.
`include "prs_defines.svh"
`default_nettype none

module prs_host_port #(
   parameter logic [23:0] DETECT_CYCLES = 24'(`PRS_DETECT_CYCLES),
   parameter logic [23:0] SETTLE_CYCLES = 24'(`PRS_SETTLE_CYCLES),
   parameter logic [23:0] SAMPLE_CYCLES = 24'(`PRS_SAMPLE_CYCLES)
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   // Straps
   input  wire logic             select_strap_pin,
   input  wire logic [3:0]       addr_strap_level,
   // SPI link
   input  wire logic             spi_sck,
   input  wire logic             spi_mosi,
   output logic                  spi_miso,
   // Two-wire link
   input  wire logic             scl_in,
   output logic                  scl_out,
   output logic                  scl_oe_b,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_b,
   // Front end
   input  wire logic [15:0]      pressure_in,
   output prs_pkg::prs_cfg_t     cfg,
   // Status
   output logic                  data_ready_out,
   output logic                  unsettled_out,
   output logic                  iface_ready,
   output logic                  spi_selected
);

   typedef struct packed {
      logic [1:0]          sel_s;
      logic [1:0]          scl_s;
      logic [1:0]          sda_s;
      logic [3:0]          lvl_m;
      logic [3:0]          lvl_s;
      logic [2:0]          tgl_s;
      logic                scl_p;
      logic                sda_p;
      logic [23:0]         por_cnt;
      logic                detected;
      logic                spi_mode;
      logic [6:0]          i2c_addr;
      logic [23:0]         settle_cnt;
      logic                unsettled;
      logic [23:0]         tick_cnt;
      logic [7:0]          rate_cnt;
      logic                data_ready;
      logic [15:0]         tx_word;
      logic [7:0]          mode_pend;
      prs_pkg::prs_cfg_t   cfg;
      prs_pkg::prs_i2c_st_t st;
      logic [3:0]          bitc;
      logic [7:0]          shreg;
      logic                rw;
      logic [1:0]          bytec;
      logic [7:0]          wr_mode;
      logic [7:0]          wr_rate;
      logic                sda_oe_b;
      logic                scl_oe_b;
      logic [10:0]         stretch;
      logic                line_out;
   } prs_core_state_t;

   prs_core_state_t s;
   prs_core_state_t next_s;
   logic [15:0]     spi_rx;
   logic            spi_tgl;

   // Auto rate: divisor doubles per bandwidth step, kept small on purpose
   function automatic logic [7:0] prs_auto_div(input logic [2:0] bw);
      prs_auto_div = 8'h01 << bw;
   endfunction

   // ----------------------------------------------------------------
   // SPI shifter on the link clock
   // ----------------------------------------------------------------
   prs_spi_shift u_spi (
      .spi_sck          (spi_sck),
      .select_strap_pin (select_strap_pin | ~s.spi_mode),
      .spi_mosi         (spi_mosi),
      .spi_miso         (spi_miso),
      .tx_word          (s.tx_word),
      .rx_word          (spi_rx),
      .done_tgl         (spi_tgl)
   );

   // ----------------------------------------------------------------
   // Core next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic       scl_rise;
      logic       scl_fall;
      logic       i2c_start;
      logic       i2c_stop;
      logic       spi_done;
      logic       read_evt;
      logic       cycle_evt;
      logic       commit;
      logic [7:0] new_mode;
      logic [7:0] new_rate;
      logic [7:0] div;
      logic [7:0] nb;
      scl_rise  = 1'b0;
      scl_fall  = 1'b0;
      i2c_start = 1'b0;
      i2c_stop  = 1'b0;
      spi_done  = 1'b0;
      read_evt  = 1'b0;
      cycle_evt = 1'b0;
      commit    = 1'b0;
      new_mode  = s.wr_mode;
      new_rate  = s.wr_rate;
      div       = 8'h00;
      nb        = 8'h00;
      next_s    = s;

      next_s.sel_s = {s.sel_s[0], select_strap_pin};
      next_s.scl_s = {s.scl_s[0], scl_in};
      next_s.sda_s = {s.sda_s[0], sda_in};
      next_s.lvl_m = addr_strap_level;
      next_s.lvl_s = s.lvl_m;
      next_s.tgl_s = {s.tgl_s[1:0], spi_tgl};
      next_s.scl_p = s.scl_s[1];
      next_s.sda_p = s.sda_s[1];

      // Interface detection, sampled exactly once
      if (!s.detected) begin
         next_s.por_cnt = s.por_cnt + 24'h000001;
         if (s.por_cnt == DETECT_CYCLES - 24'h000001) begin
            next_s.detected = 1'b1;
            next_s.spi_mode = s.sel_s[1];
            next_s.i2c_addr = `PRS_I2C_BASE_ADDR + 7'((s.lvl_s > `PRS_I2C_ADDR_MAX) ?
                              `PRS_I2C_ADDR_MAX : s.lvl_s);
         end
      end
      if (s.unsettled) begin
         next_s.settle_cnt = s.settle_cnt + 24'h000001;
         if (s.settle_cnt == SETTLE_CYCLES - 24'h000001) begin
            next_s.unsettled = 1'b0;
         end
      end

      // Link events are ignored until detection is over
      scl_rise  = s.detected && !s.spi_mode && s.scl_s[1] && !s.scl_p;
      scl_fall  = s.detected && !s.spi_mode && !s.scl_s[1] && s.scl_p;
      i2c_start = s.detected && !s.spi_mode && s.scl_s[1] && s.scl_p && s.sda_p && !s.sda_s[1];
      i2c_stop  = s.detected && !s.spi_mode && s.scl_s[1] && s.scl_p && !s.sda_p && s.sda_s[1];
      spi_done  = s.detected && s.spi_mode && s.tgl_s[1] && !s.tgl_s[2]; // Deselect clears the toggle

      // Clock stretch after each acknowledge
      if (s.stretch != 11'h000) begin
         next_s.stretch = s.stretch - 11'h001;
         if (s.stretch == 11'h001) begin
            next_s.scl_oe_b = 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // Two-wire slave, never drives a clock edge of its own
      // ----------------------------------------------------------------
      if (i2c_start) begin
         next_s.st       = prs_pkg::PRS_ADDR;
         next_s.bitc     = 4'h0;
         next_s.sda_oe_b = 1'b1;
      end else if (i2c_stop) begin
         if (s.st != prs_pkg::PRS_IDLE && s.st != prs_pkg::PRS_ADDR) begin
            cycle_evt = 1'b1;
            commit    = !s.rw && (s.bytec == 2'h2);
         end
         next_s.st       = prs_pkg::PRS_IDLE;
         next_s.sda_oe_b = 1'b1;
      end else begin
         unique case (s.st)
            prs_pkg::PRS_IDLE: begin
            end
            prs_pkg::PRS_ADDR: begin
               if (scl_rise && s.bitc != 4'h8) begin
                  next_s.shreg = {s.shreg[6:0], s.sda_s[1]};
                  next_s.bitc  = s.bitc + 4'h1;
               end else if (scl_fall && s.bitc == 4'h8) begin
                  if (s.shreg[7:1] == s.i2c_addr) begin
                     next_s.st       = prs_pkg::PRS_ADDR_ACK;
                     next_s.sda_oe_b = 1'b0;
                     next_s.rw       = s.shreg[0];
                  end else begin
                     next_s.st = prs_pkg::PRS_IDLE;
                  end
               end
            end
            prs_pkg::PRS_ADDR_ACK: begin
               if (scl_fall) begin
                  next_s.scl_oe_b = 1'b0;
                  next_s.stretch  = `PRS_STRETCH_CYCLES;
                  next_s.bitc     = 4'h0;
                  if (s.rw) begin
                     read_evt        = 1'b1;
                     next_s.shreg    = s.tx_word[15:8];
                     next_s.sda_oe_b = s.tx_word[15];
                     next_s.bytec    = 2'h1;
                     next_s.st       = prs_pkg::PRS_RD_BYTE;
                  end else begin
                     next_s.sda_oe_b = 1'b1;
                     next_s.bytec    = 2'h0;
                     next_s.st       = prs_pkg::PRS_WR_BYTE;
                  end
               end
            end
            prs_pkg::PRS_WR_BYTE: begin
               if (scl_rise && s.bitc != 4'h8) begin
                  next_s.shreg = {s.shreg[6:0], s.sda_s[1]};
                  next_s.bitc  = s.bitc + 4'h1;
               end else if (scl_fall && s.bitc == 4'h8) begin
                  if (s.bytec == 2'h0) begin
                     next_s.wr_mode = s.shreg;
                  end else if (s.bytec == 2'h1) begin
                     next_s.wr_rate = s.shreg;
                  end
                  if (s.bytec != 2'h2) begin
                     next_s.bytec = s.bytec + 2'h1;
                  end
                  next_s.sda_oe_b = 1'b0;
                  next_s.st       = prs_pkg::PRS_WR_ACK;
               end
            end
            prs_pkg::PRS_WR_ACK: begin
               if (scl_fall) begin
                  next_s.sda_oe_b = 1'b1;
                  next_s.scl_oe_b = 1'b0;
                  next_s.stretch  = `PRS_STRETCH_CYCLES;
                  next_s.bitc     = 4'h0;
                  next_s.st       = prs_pkg::PRS_WR_BYTE;
               end
            end
            prs_pkg::PRS_RD_BYTE: begin
               if (scl_rise) begin
                  next_s.bitc = s.bitc + 4'h1;
               end else if (scl_fall && s.bitc == 4'h8) begin
                  next_s.sda_oe_b = 1'b1;
                  next_s.st       = prs_pkg::PRS_RD_ACK;
               end else if (scl_fall) begin
                  next_s.shreg    = {s.shreg[6:0], 1'b0};
                  next_s.sda_oe_b = s.shreg[6];
               end
            end
            prs_pkg::PRS_RD_ACK: begin
               if (scl_rise && s.sda_s[1]) begin
                  cycle_evt = 1'b1;
                  next_s.st = prs_pkg::PRS_IDLE;
               end else if (scl_fall) begin
                  // Extended data is not provided; further bytes read zero
                  nb              = (s.bytec == 2'h1) ? s.tx_word[7:0] : 8'h00;
                  next_s.shreg    = nb;
                  next_s.sda_oe_b = nb[7];
                  next_s.bytec    = 2'h2;
                  next_s.bitc     = 4'h0;
                  next_s.scl_oe_b = 1'b0;
                  next_s.stretch  = `PRS_STRETCH_CYCLES;
                  next_s.st       = prs_pkg::PRS_RD_BYTE;
               end
            end
            default: begin
               next_s.st = prs_pkg::PRS_IDLE;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Configuration registers
      // ----------------------------------------------------------------
      if (spi_done) begin
         read_evt  = 1'b1;
         cycle_evt = 1'b1;
         commit    = 1'b1;
         new_mode  = spi_rx[15:8];
         new_rate  = spi_rx[7:0];
      end
      if (cycle_evt) begin
         next_s.cfg.mode = s.mode_pend;
      end
      if (commit) begin
         next_s.mode_pend = new_mode;
         next_s.cfg.rate  = new_rate;
      end

      // ----------------------------------------------------------------
      // Update tick, rate divider and data ready
      // ----------------------------------------------------------------
      div = (s.cfg.rate == 8'h00) ?
            prs_auto_div(s.cfg.mode[`PRS_BW_LSB +: 3]) : s.cfg.rate;
      next_s.tick_cnt = s.tick_cnt + 24'h000001;
      if (read_evt) begin
         next_s.data_ready = 1'b0;
      end
      if (s.tick_cnt == SAMPLE_CYCLES - 24'h000001) begin
         next_s.tick_cnt = 24'h000000;
         // The SPI shifter reads this word only while selected
         if (s.sel_s[1] || !s.spi_mode) begin
            if (s.st == prs_pkg::PRS_IDLE) begin
               next_s.tx_word = pressure_in;
            end
         end
         if (s.rate_cnt <= 8'h01) begin
            next_s.rate_cnt   = div;
            next_s.data_ready = s.detected;
         end else begin
            next_s.rate_cnt = s.rate_cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s           <= '0;
         s.sel_s     <= 2'h3;
         s.scl_s     <= 2'h3;
         s.sda_s     <= 2'h3;
         s.scl_p     <= 1'b1;
         s.sda_p     <= 1'b1;
         s.unsettled <= 1'b1;
         s.mode_pend <= `PRS_MODE_RESET;
         s.cfg       <= '{mode: `PRS_MODE_RESET, rate: `PRS_RATE_RESET};
         s.st        <= prs_pkg::PRS_IDLE;
         s.sda_oe_b  <= 1'b1;
         s.scl_oe_b  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign cfg            = s.cfg;
   assign data_ready_out = s.data_ready;
   assign unsettled_out  = s.unsettled;
   assign iface_ready    = s.detected;
   assign spi_selected   = s.spi_mode;
   assign scl_out        = s.line_out;
   assign sda_out        = s.line_out;
   assign scl_oe_b       = s.scl_oe_b;
   assign sda_oe_b       = s.sda_oe_b;

endmodule // prs_host_port

`default_nettype wire

//--- core/prs_pkg.sv
`default_nettype none

package prs_pkg;

   // ----------------------------------------------------------------
   // Configuration carried to the front end
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] rate;
   } prs_cfg_t;

   // ----------------------------------------------------------------
   // Two-wire slave states
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      PRS_IDLE     = 7'h01,
      PRS_ADDR     = 7'h02,
      PRS_ADDR_ACK = 7'h04,
      PRS_WR_BYTE  = 7'h08,
      PRS_WR_ACK   = 7'h10,
      PRS_RD_BYTE  = 7'h20,
      PRS_RD_ACK   = 7'h40
   } prs_i2c_st_t;

endpackage

`default_nettype wire

//--- core/prs_spi_shift.sv
`include "prs_defines.svh"
`default_nettype none

module prs_spi_shift (
   // Link clock and frame select
   input  wire logic        spi_sck,
   input  wire logic        select_strap_pin,
   // Serial data
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   // Core side, quasi-static words
   input  wire logic [15:0] tx_word,
   output logic [15:0] rx_word,
   output logic        done_tgl
);

   typedef struct packed {
      logic [15:0] shreg;
      logic [4:0]  cnt;
      logic [15:0] rx;
      logic        tgl;
   } prs_spi_state_t;

   prs_spi_state_t s;
   prs_spi_state_t next_s;
   logic           miso_q;

   // ----------------------------------------------------------------
   // Sampling on the rising edge
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (s.cnt != `PRS_SPI_BITS) begin
         next_s.shreg = {s.shreg[14:0], spi_mosi};
         next_s.cnt   = s.cnt + 5'h01;
         if (s.cnt == `PRS_SPI_BITS - 5'h01) begin
            // Mode byte then rate byte; later bytes are ignored
            next_s.rx  = {s.shreg[14:0], spi_mosi};
            next_s.tgl = ~s.tgl;
         end
      end
   end

   // Deselect resets the frame, so a short frame never toggles
   always_ff @(posedge spi_sck or posedge select_strap_pin) begin
      if (select_strap_pin) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Shifting out on the falling edge
   // ----------------------------------------------------------------
   always_ff @(negedge spi_sck or posedge select_strap_pin) begin
      if (select_strap_pin) begin
         miso_q <= 1'b0;
      end else if (s.cnt == `PRS_SPI_BITS) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= tx_word[4'hF - s.cnt[3:0]];
      end
   end

   // MSB must stand before the first edge, so it bypasses the flop
   assign spi_miso = (select_strap_pin) ? 1'b0 : ((s.cnt == 5'h00) ? tx_word[15] : miso_q);
   assign rx_word  = s.rx;
   assign done_tgl = s.tgl;

endmodule // prs_spi_shift

`default_nettype wire

//--- sim/prs_host_model.sv
`default_nettype none

module prs_host_model #(
   parameter int GAP_NS = 200
) (
   // Serial master
   output logic      select_strap_pin,
   output logic      spi_sck,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   // Two-wire drive and line levels
   output logic      scl_m,
   output logic      sda_m,
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      hang
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      select_strap_pin = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
      scl_m = 1'b1;
      sda_m = 1'b1;
      hang = 1'b0;
   end

   task automatic strap(input logic v);
      select_strap_pin = v;
   endtask

   // Gaps scaled far below the host minimums to keep runs short
   task automatic spi_xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      int i;
      rx = 16'h0000;
      select_strap_pin = 1'b0;
      #(GAP_NS);
      for (i = 0; i < n; i++) begin
         spi_mosi = tx[15 - i];
         #7.5 spi_sck = 1'b1;
         rx[15 - i] = spi_miso;
         #7.5 spi_sck = 1'b0;
         if (i == 7) #(GAP_NS);
      end
      #(GAP_NS);
      select_strap_pin = 1'b1;
      #(GAP_NS);
   endtask

   // Device may hold the clock low
   task automatic scl_up();
      int k;
      scl_m = 1'b1;
      for (k = 0; k < 4000 && !scl_w; k++) #10;
      if (!scl_w) hang = 1'b1;
      #150;
   endtask

   task automatic i2c_bit(input logic b, output logic r);
      sda_m = b;
      #150;
      scl_up();
      r = sda_w;
      scl_m = 1'b0;
      #100;
   endtask

   task automatic i2c_byte(input logic [7:0] d, input logic m, output logic ack, output logic [7:0] q);
      int i;
      logic r;
      for (i = 7; i >= 0; i--) i2c_bit(d[i], q[i]);
      i2c_bit(m, r);
      ack = !r;
   endtask

   // Read: ack the first byte, not the second
   task automatic i2c_xfer(input logic [7:0] a, input logic [15:0] d, output logic [2:0] acks,
                           output logic [15:0] q);
      logic [7:0] u;
      sda_m = 1'b0;
      #150;
      scl_m = 1'b0;
      #100;
      i2c_byte(a, 1'b1, acks[2], u);
      i2c_byte(d[15:8], !a[0], acks[1], q[15:8]);
      i2c_byte(d[7:0], 1'b1, acks[0], q[7:0]);
      sda_m = 1'b0;
      #150;
      scl_up();
      sda_m = 1'b1;
      #300;
   endtask
endmodule // prs_host_model

`default_nettype wire

//--- sim/prs_host_port_chk.sv
`default_nettype none

module prs_host_port_chk #(
   parameter logic [23:0] DETECT_CYCLES = 24'h000032,
   parameter logic [23:0] SETTLE_CYCLES = 24'h000064,
   parameter logic [23:0] SAMPLE_CYCLES = 24'h000014
) (
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              rst_b,
   // Link pins
   input wire logic              select_strap_pin,
   input wire logic              spi_miso,
   input wire logic              scl_oe_b,
   input wire logic              sda_oe_b,
   // Status
   input wire prs_pkg::prs_cfg_t cfg,
   input wire logic              data_ready_out,
   input wire logic              unsettled_out,
   input wire logic              iface_ready,
   input wire logic              spi_selected
);
   logic [23:0] age;
   logic [31:0] gap;
   logic        seen;
   logic        ready_q;
   logic        rise;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   assign rise = data_ready_out && !ready_q;

   // Gap is trusted only after one rise under a steady configuration
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         age <= 24'h000000;
         gap <= 32'h00000001;
         seen <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         age <= (age == 24'hFFFFFF) ? age : age + 24'h000001;
         gap <= rise ? 32'h00000001 : gap + 32'h00000001;
         seen <= $changed(cfg) ? 1'b0 : (rise ? 1'b1 : seen);
         ready_q <= data_ready_out;
      end
   end

   sequence s_stretch;
      !scl_oe_b [*8];
   endsequence

   property p_detect_early;
      (age < DETECT_CYCLES - 24'h000001) |-> !iface_ready;
   endproperty
   a_detect_early: assert property (p_detect_early) else $error("ready before detect delay");
   property p_detect_late;
      (age > DETECT_CYCLES + 24'h000001) |-> iface_ready;
   endproperty
   a_detect_late: assert property (p_detect_late) else $error("detection never finished");
   property p_select_once;
      iface_ready |=> iface_ready && $stable(spi_selected);
   endproperty
   a_select_once: assert property (p_select_once) else $error("interface choice moved");
   property p_settle;
      (age < SETTLE_CYCLES - 24'h000001) |-> unsettled_out;
   endproperty
   a_settle: assert property (p_settle) else $error("settled flag too early");
   property p_settle_late;
      (age > SETTLE_CYCLES + 24'h000001) |-> !unsettled_out;
   endproperty
   a_settle_late: assert property (p_settle_late) else $error("settled flag never cleared");
   property p_cfg_reset;
      $rose(rst_b) |-> cfg == 16'hF600;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("configuration reset value wrong");
   property p_miso_idle;
      select_strap_pin |-> !spi_miso;
   endproperty
   a_miso_idle: assert property (p_miso_idle) else $error("serial out active while deselected");
   property p_spi_quiet;
      iface_ready && spi_selected |-> scl_oe_b && sda_oe_b;
   endproperty
   a_spi_quiet: assert property (p_spi_quiet) else $error("two-wire pins driven in serial mode");
   property p_stretch;
      $fell(scl_oe_b) |-> s_stretch;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock stretch too short");
   property p_rate_period;
      rise && seen && cfg.rate != 8'h00 |-> gap % (32'(cfg.rate) * 32'(SAMPLE_CYCLES)) == 32'h00000000;
   endproperty
   a_rate_period: assert property (p_rate_period) else $error("data ready period wrong");
endmodule // prs_host_port_chk

bind prs_host_port prs_host_port_chk #(.DETECT_CYCLES(DETECT_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES),
   .SAMPLE_CYCLES(SAMPLE_CYCLES)) u_prs_host_port_chk (.core_clk(core_clk), .rst_b(rst_b),
   .select_strap_pin(select_strap_pin), .spi_miso(spi_miso), .scl_oe_b(scl_oe_b), .sda_oe_b(sda_oe_b),
   .cfg(cfg), .data_ready_out(data_ready_out), .unsettled_out(unsettled_out), .iface_ready(iface_ready),
   .spi_selected(spi_selected));

`default_nettype wire

//--- sim/prs_host_port_tb_top.sv
`default_nettype none

module prs_host_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic              core_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic [3:0]        addr_strap_level = 4'h0;
   logic [15:0]       pressure_in = 16'hA5C3;
   logic              sel, sck, mosi, miso, scl_m, sda_m, scl_w, sda_w, hang;
   logic              scl_out, scl_oe_b, sda_out, sda_oe_b;
   logic              data_ready_out, unsettled_out, iface_ready, spi_selected;
   logic [2:0]        acks;
   logic [15:0]       rd;
   prs_pkg::prs_cfg_t cfg;
   int                bad_count = 0;
   int                cmp_count = 0;

   always #4 core_clk = ~core_clk;
   // Pulled-up open-drain lines
   assign scl_w = scl_m & (scl_oe_b | scl_out);
   assign sda_w = sda_m & (sda_oe_b | sda_out);

   prs_host_port #(.DETECT_CYCLES(24'h000032), .SETTLE_CYCLES(24'h000064), .SAMPLE_CYCLES(24'h000014))
      u_prs_host_port (.core_clk(core_clk), .rst_b(rst_b), .select_strap_pin(sel),
      .addr_strap_level(addr_strap_level), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
      .pressure_in(pressure_in), .cfg(cfg), .data_ready_out(data_ready_out), .unsettled_out(unsettled_out),
      .iface_ready(iface_ready), .spi_selected(spi_selected));

   prs_host_model u_prs_host_model (.select_strap_pin(sel), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
      .scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w), .sda_w(sda_w), .hang(hang));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset(input logic strap, input logic [3:0] lvl);
      int k;
      rst_b = 1'b0;
      u_prs_host_model.strap(strap);
      addr_strap_level = lvl;
      repeat (4) @(negedge core_clk);
      rst_b = 1'b1;
      chk(cfg, 16'hF600);
      for (k = 0; k < 200 && !iface_ready; k++) @(negedge core_clk);
      repeat (8) @(negedge core_clk);
      chk({13'h0000, unsettled_out, iface_ready, spi_selected}, {13'h0000, 2'b11, strap});
      if (!iface_ready) stop_test();
   endtask

   task automatic wait_ready(input int n);
      int k;
      for (k = 0; k < n && !data_ready_out; k++) @(negedge core_clk);
      chk({15'h0000, data_ready_out}, 16'h0001);
      if (!data_ready_out) stop_test();
   endtask

   task automatic frame(input logic [15:0] tx, input int n, input logic [15:0] ecfg, input logic [15:0] erx);
      logic [15:0] rx;
      u_prs_host_model.spi_xfer(tx, n, rx);
      if (n == 16) chk(rx, erx);
      chk(cfg, ecfg);
   endtask

   initial begin
      do_reset(1'b1, 4'h0);
      repeat (50) @(negedge core_clk);
      frame(16'h3510, 16, 16'hF610, 16'hA5C3);
      pressure_in = 16'h5A3C;
      wait_ready(2600);
      frame(16'h3510, 16, 16'h3510, 16'h5A3C);
      chk({15'h0000, data_ready_out}, 16'h0000);
      wait_ready(360);
      frame(16'h3510, 16, 16'h3510, 16'h5A3C);
      wait_ready(360);
      frame(16'h4700, 9, 16'h3510, 16'h0000);
      chk({15'h0000, data_ready_out}, 16'h0001);
      frame(16'h4700, 16, 16'h3500, 16'h5A3C);
      wait_ready(200);
      $display("serial link test done");
      do_reset(1'b0, 4'h3);
      u_prs_host_model.i2c_xfer(8'h54, 16'h1205, acks, rd);
      chk({13'h0000, acks}, 16'h0000);
      chk(cfg, 16'hF600);
      u_prs_host_model.i2c_xfer(8'h56, 16'h1205, acks, rd);
      chk({13'h0000, acks}, 16'h0007);
      repeat (8) @(negedge core_clk);
      chk(cfg, 16'hF605);
      u_prs_host_model.i2c_xfer(8'h57, 16'hFFFF, acks, rd);
      chk(rd, 16'h5A3C);
      chk({13'h0000, acks}, 16'h0006);
      chk(cfg, 16'h1205);
      chk({15'h0000, hang}, 16'h0000);
      $display("two-wire test done");
      stop_test();
   end
endmodule // prs_host_port_tb_top

`default_nettype wire
